// ===== include/regfile_map_consts.vh
`ifndef REGFILE_MAP_CONSTS_VH
`define REGFILE_MAP_CONSTS_VH
// Register addresses and reset values
`define SET1_BASE 8'hC0
`define BANKED_BASE 8'hE0
`define SYSREG_BASE 8'hD0
`define WORK_PREFIX 4'hC
`define PTR_LO_ADDR 8'hD6
`define PTR_HI_ADDR 8'hD7
`define PAGE_SEL_ADDR 8'hDF
`define PTR_LO_RESET 8'hC0
`define PTR_HI_RESET 8'hC8
`define PAGE_SEL_RESET 8'h00
`define PTR_PAIR_STEP 8'h08
`define PAGE_COUNT 3'h6
`define PRIME_PAGES 3'h4
// Address modes on MODE input
`define MODE_DIRECT 2'h0
`define MODE_INDIRECT 2'h1
`define MODE_INDEXED 2'h2
`define MODE_WORKING 2'h3
// Pointer instruction codes on PTR_OP input
`define OP_NONE 3'h0
`define OP_SET_BOTH 3'h1
`define OP_SET_FIRST 3'h2
`define OP_SET_SECOND 3'h3
`define OP_BANK_ZERO 3'h4
`define OP_BANK_ONE 3'h5
// Physical index: 4 pages x 256 plus set 2 (4 x 64) plus bank 1 (32)
`define PHYS_W 11
`define SET2_OFFSET 11'h400
`define BANK1_OFFSET 11'h500
`endif

// ===== design/banked_paged_register_file.v
`timescale 1ns/100ps
`default_nettype none
`include "regfile_map_consts.vh"
module banked_paged_register_file
(
   // Clock and reset
   input wire CLK,
   input wire RESET,
   // Access request
   input wire REQ,
   input wire WR,
   input wire PAIR,
   input wire [1:0] MODE,
   input wire [7:0] ADDR,
   input wire [15:0] WDATA,
   // Pointer and bank instructions
   input wire [2:0] PTR_OP,
   input wire [7:0] PTR_OPERAND,
   // Read answer
   output reg [15:0] RDATA,
   output reg RVALID,
   output reg ERR,
   // Resolved location of current request
   output wire [10:0] PHYS_ADDR,
   // State view
   output wire BANK_SEL,
   output wire [7:0] PAGE_SEL,
   output wire [7:0] PTR_LO,
   output wire [7:0] PTR_HI
);

   reg [7:0] mem [0:1535];
   reg bank_q;
   reg [7:0] page_q;
   reg [7:0] ptr_lo_q;
   reg [7:0] ptr_hi_q;

   // Working register address from 4-bit field
   function [7:0] work_addr;
      input [3:0] nib;
      input [7:0] p0;
      input [7:0] p1;
      begin
         work_addr = {(nib[3] ? p1[7:3] : p0[7:3]), nib[2:0]};
      end
   endfunction

   // Logical address to physical index
   function [10:0] resolve;
      input [7:0] a;
      input [1:0] mode;
      input [3:0] page;
      input bank;
      reg [1:0] pg;
      begin
         pg = page[1:0];
         resolve = 11'h000;
         if (a < `SET1_BASE)
         begin
            resolve = {1'b0, pg, a};
         end
         else if ((mode == `MODE_INDIRECT) || (mode == `MODE_INDEXED))
         begin
            resolve = `SET2_OFFSET | {3'h0, pg, a[5:0]};
         end
         else if ((a >= `BANKED_BASE) && bank)
         begin
            resolve = `BANK1_OFFSET | {6'h00, a[4:0]};
         end
         else
         begin
            resolve = {3'h0, a};
         end
      end
   endfunction

   // Byte seen by a read of one logical location
   function [7:0] read_byte;
      input [7:0] la;
      input set1;
      input [7:0] store;
      input [7:0] lo;
      input [7:0] hi;
      input [7:0] pg;
      begin
         if (set1 && (la == `PTR_LO_ADDR))
         begin
            read_byte = lo;
         end
         else if (set1 && (la == `PTR_HI_ADDR))
         begin
            read_byte = hi;
         end
         else if (set1 && (la == `PAGE_SEL_ADDR))
         begin
            read_byte = pg;
         end
         else
         begin
            read_byte = store;
         end
      end
   endfunction

   // Address resolution for the current request
   reg [7:0] log_addr;
   reg [1:0] eff_mode;
   wire [3:0] page_nib = WR ? page_q[7:4] : page_q[3:0];
   wire [10:0] phys = resolve(log_addr, eff_mode, page_nib, bank_q);
   wire [10:0] phys_odd = {phys[10:1], 1'b1};
   wire [10:0] phys_even = {phys[10:1], 1'b0};

   // Working field and 1100B escape both go through the slice pointers
   always @*
   begin
      log_addr = ADDR;
      eff_mode = MODE;
      if (MODE == `MODE_WORKING)
      begin
         log_addr = work_addr(ADDR[3:0], ptr_lo_q, ptr_hi_q);
         eff_mode = `MODE_DIRECT;
      end
      else if ((MODE == `MODE_DIRECT) && (ADDR[7:4] == `WORK_PREFIX))
      begin
         // Direct C0H-CFH never reaches that range as plain register access
         log_addr = work_addr(ADDR[3:0], ptr_lo_q, ptr_hi_q);
      end
   end

   // Region of the resolved logical address
   wire in_prime = (log_addr < `SET1_BASE);
   wire in_upper = ~in_prime;
   wire via_pointer = (eff_mode == `MODE_INDIRECT) || (eff_mode == `MODE_INDEXED);
   wire in_set2 = in_upper & via_pointer;
   wire in_set1 = in_upper & ~via_pointer;
   wire page_beyond = (page_nib >= {1'b0, `PRIME_PAGES});

   // Pages 4 and up have no prime or set 2 storage behind them
   wire prime_refused = in_prime & page_beyond;
   wire set2_refused = in_set2 & page_beyond;
   wire err_now = prime_refused | set2_refused;
   wire take = REQ & ~err_now;
   wire take_wr = take & WR;
   wire take_rd = take & ~WR;
   assign PHYS_ADDR = phys;

   // Mapped registers in the set 1 system area
   wire hits_lo = in_set1 && (log_addr == `PTR_LO_ADDR);
   wire hits_hi = in_set1 && (log_addr == `PTR_HI_ADDR);
   wire hits_pg = in_set1 && (log_addr == `PAGE_SEL_ADDR);
   wire [7:0] even_addr = {log_addr[7:1], 1'b0};
   wire pair_ptr = in_set1 && (even_addr == `PTR_LO_ADDR);
   wire pair_pg = in_set1 && (even_addr == (`PAGE_SEL_ADDR & 8'hFE));

   // A pointer or bank instruction owns the cycle; pointer and page loads in that cycle are dropped
   wire op_idle = (PTR_OP == `OP_NONE) || (PTR_OP > `OP_BANK_ONE);
   wire lo_wr = op_idle & take_wr & (PAIR ? pair_ptr : hits_lo);
   wire hi_wr = op_idle & take_wr & (PAIR ? pair_ptr : hits_hi);
   wire pg_wr = op_idle & take_wr & (PAIR ? pair_pg : hits_pg);
   wire [7:0] lo_wdata = PAIR ? WDATA[15:8] : WDATA[7:0];
   wire [7:0] hi_wdata = WDATA[7:0];

   // Read bytes: single, and both halves of a pair
   wire [7:0] single_byte = read_byte(log_addr, in_set1, mem[phys], ptr_lo_q, ptr_hi_q,
      page_q);
   wire [7:0] pair_byte [0:1];
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_pair
         wire odd_bit = (gi == 1) ? 1'b1 : 1'b0;
         wire [7:0] la_b = {log_addr[7:1], odd_bit};
         wire [10:0] pa_b = {phys[10:1], odd_bit};
         assign pair_byte[gi] = read_byte(la_b, in_set1, mem[pa_b], ptr_lo_q, ptr_hi_q,
            page_q);
      end
   endgenerate

   // Bank select, changed only by the two bank instructions
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         bank_q <= 1'b0;
      end
      else if (PTR_OP == `OP_BANK_ZERO)
      begin
         bank_q <= 1'b0;
      end
      else if (PTR_OP == `OP_BANK_ONE)
      begin
         bank_q <= 1'b1;
      end
   end

   // Page select, loaded like any set 1 register
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         page_q <= `PAGE_SEL_RESET;
      end
      else if (pg_wr)
      begin
         page_q <= WDATA[7:0];
      end
   end

   // Slice pointers: instructions first, then ordinary loads
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         ptr_lo_q <= `PTR_LO_RESET;
         ptr_hi_q <= `PTR_HI_RESET;
      end
      else
      begin
         case (PTR_OP)
            `OP_SET_BOTH:
            begin
               ptr_lo_q <= PTR_OPERAND;
               ptr_hi_q <= PTR_OPERAND + `PTR_PAIR_STEP;
            end
            `OP_SET_FIRST:
            begin
               ptr_lo_q <= PTR_OPERAND;
            end
            `OP_SET_SECOND:
            begin
               ptr_hi_q <= PTR_OPERAND;
            end
            default:
            begin
               if (lo_wr)
               begin
                  ptr_lo_q <= lo_wdata;
               end
               if (hi_wr)
               begin
                  ptr_hi_q <= hi_wdata;
               end
            end
         endcase
      end
   end

   // Read answer and refusal flag, one cycle after the request
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         RDATA <= 16'h0000;
         RVALID <= 1'b0;
         ERR <= 1'b0;
      end
      else
      begin
         RVALID <= take_rd;
         ERR <= REQ & err_now;
         if (take_rd && PAIR)
         begin
            RDATA <= {pair_byte[0], pair_byte[1]};
         end
         else if (take_rd)
         begin
            RDATA <= {8'h00, single_byte};
         end
      end
   end

   // Storage array; no reset so it maps to RAM
   always @(posedge CLK)
   begin
      if (REQ && WR && !err_now)
      begin
         if (PAIR)
         begin
            mem[phys_even] <= WDATA[15:8];
            mem[phys_odd] <= WDATA[7:0];
         end
         else
            mem[phys] <= WDATA[7:0];
      end
   end

   assign BANK_SEL = bank_q;
   assign PAGE_SEL = page_q;
   assign PTR_LO = ptr_lo_q;
   assign PTR_HI = ptr_hi_q;

endmodule // banked_paged_register_file
`default_nettype wire

// ===== sim/regfile_chk_properties.sv
`timescale 1ns/100ps
`default_nettype none
module regfile_chk
(
   // Watched ports
   input wire CLK,
   input wire RESET,
   input wire REQ,
   input wire WR,
   input wire [1:0] MODE,
   input wire [7:0] ADDR,
   input wire [2:0] PTR_OP,
   input wire [7:0] PTR_OPERAND,
   input wire [10:0] PHYS_ADDR,
   input wire BANK_SEL,
   input wire [7:0] PAGE_SEL,
   input wire [7:0] PTR_LO,
   input wire [7:0] PTR_HI
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);
   wire [7:0] wp = ADDR[3] ? PTR_HI : PTR_LO;
   wire [7:0] wa = {wp[7:3], ADDR[2:0]};
   property p_b0; PTR_OP == 3'h4 |=> !BANK_SEL; endproperty
   a_b0: assert property (p_b0) else $error("bank zero");
   property p_b1; PTR_OP == 3'h5 |=> BANK_SEL; endproperty
   a_b1: assert property (p_b1) else $error("bank one");
   property p_both; PTR_OP == 3'h1 |=> PTR_LO == $past(PTR_OPERAND)
      && PTR_HI == $past(PTR_OPERAND) + 8'h08; endproperty
   a_both: assert property (p_both) else $error("set both");
   property p_one; PTR_OP == 3'h2 |=> PTR_LO == $past(PTR_OPERAND) && $stable(PTR_HI); endproperty
   a_one: assert property (p_one) else $error("set first");
   property p_two; PTR_OP == 3'h3 |=> PTR_HI == $past(PTR_OPERAND) && $stable(PTR_LO); endproperty
   a_two: assert property (p_two) else $error("set second");
   property p_wk; REQ && !BANK_SEL && (MODE == 2'h3 || MODE == 2'h0 && ADDR[7:4] == 4'hC)
      |-> PHYS_ADDR[7:0] == wa; endproperty
   a_wk: assert property (p_wk) else $error("working address");
   property p_s2; REQ && !WR && MODE == 2'h1 && ADDR >= 8'hC0 && PAGE_SEL[3:2] == 2'h0
      |-> PHYS_ADDR[10:8] == 3'h4; endproperty
   a_s2: assert property (p_s2) else $error("set 2 decode");
   property p_sys; REQ && MODE == 2'h0 && ADDR[7:4] == 4'hD |-> PHYS_ADDR == {3'h0, ADDR}; endproperty
   a_sys: assert property (p_sys) else $error("set 1 direct");
   property p_pr; REQ && !WR && MODE == 2'h0 && ADDR < 8'hC0 && PAGE_SEL[3:2] == 2'h0
      |-> PHYS_ADDR == {1'b0, PAGE_SEL[1:0], ADDR}; endproperty
   a_pr: assert property (p_pr) else $error("prime page");
endmodule // regfile_chk
bind banked_paged_register_file regfile_chk chk (.CLK(CLK), .RESET(RESET), .REQ(REQ), .WR(WR),
   .MODE(MODE), .ADDR(ADDR), .PTR_OP(PTR_OP), .PTR_OPERAND(PTR_OPERAND), .PHYS_ADDR(PHYS_ADDR),
   .BANK_SEL(BANK_SEL), .PAGE_SEL(PAGE_SEL), .PTR_LO(PTR_LO), .PTR_HI(PTR_HI));
`default_nettype wire

// ===== sim/cpu_bus.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_bus
(
   // Clock
   input wire clk,
   // Request lines
   output var logic req,
   output var logic wr,
   output var logic pair,
   output var logic [1:0] mode,
   output var logic [7:0] addr,
   output var logic [15:0] wdata,
   output var logic [2:0] op,
   output var logic [7:0] opnd
);
   initial {req, wr, pair, mode, addr, wdata, op, opnd} = '0;
   // Request held over one taken edge, then req dropped and addr and wdata inverted
   task acc(input logic w, p, input logic [1:0] m, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 {req, wr, pair, mode, addr, wdata} = {1'b1, w, p, m, a, d};
      @(posedge clk);
      #1 {req, addr, wdata} = {1'b0, ~addr, ~wdata};
   endtask
   task pop(input logic [2:0] c, input logic [7:0] v);
      @(posedge clk);
      #1 {op, opnd} = {c, v};
      @(posedge clk);
      #1 {op, opnd} = {3'h0, ~opnd};
   endtask
endmodule // cpu_bus
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic CLK = 1'b0, RESET = 1'b1, req, wr, pair, rvalid, err, bank;
   logic [1:0] mode;
   logic [2:0] op;
   logic [7:0] addr, opnd, page, plo, phi;
   logic [10:0] phys;
   logic [15:0] wdata, rdata;
   int errors = 0, cmp_count = 0;
   always #4 CLK = ~CLK;
   cpu_bus bus (.clk(CLK), .req(req), .wr(wr), .pair(pair), .mode(mode), .addr(addr),
      .wdata(wdata), .op(op), .opnd(opnd));
   banked_paged_register_file dut (.CLK(CLK), .RESET(RESET), .REQ(req), .WR(wr), .PAIR(pair),
      .MODE(mode), .ADDR(addr), .WDATA(wdata), .PTR_OP(op), .PTR_OPERAND(opnd), .RDATA(rdata),
      .RVALID(rvalid), .ERR(err), .PHYS_ADDR(phys), .BANK_SEL(bank), .PAGE_SEL(page),
      .PTR_LO(plo), .PTR_HI(phi));
   task chk(input string n, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task w(input logic [1:0] m, input logic [7:0] a, input logic [15:0] d);
      bus.acc(1'b1, 1'b0, m, a, d);
   endtask
   task r(input logic [1:0] m, input logic [7:0] a, e);
      bus.acc(1'b0, 1'b0, m, a, 16'h0000);
      chk("rvalid", 16'h0001, {15'h0000, rvalid});
      chk("rdata", {8'h00, e}, {8'h00, rdata[7:0]});
   endtask
   task t_reset;
      chk("ptr", 16'hC0C8, {plo, phi});
      chk("page", 16'h0000, {8'h00, page});
      chk("bank", 16'h0000, {15'h0000, bank});
   endtask
   task t_ptr;
      bus.pop(3'h1, 8'h70);
      chk("ptr", 16'h7078, {plo, phi});
      bus.pop(3'h3, 8'h48);
      bus.pop(3'h2, 8'hA0);
      chk("ptr", 16'hA048, {plo, phi});
      w(2'h0, 8'hD7, 16'h00F8);
      chk("ptr", 16'hA0F8, {plo, phi});
      r(2'h0, 8'hD6, 8'hA0);
   endtask
   task t_page;
      w(2'h0, 8'hDF, 16'h0021);
      r(2'h0, 8'hDF, 8'h21);
      w(2'h0, 8'h10, 16'h00AA);
      w(2'h0, 8'hDF, 16'h0012);
      w(2'h0, 8'h10, 16'h0055);
      r(2'h0, 8'h10, 8'hAA);
      w(2'h0, 8'hDF, 16'h0021);
      r(2'h0, 8'h10, 8'h55);
   endtask
   task t_bank;
      bus.pop(3'h5, 8'h00);
      w(2'h0, 8'hE5, 16'h003C);
      bus.pop(3'h4, 8'h00);
      w(2'h0, 8'hE5, 16'h00C3);
      r(2'h0, 8'hE5, 8'hC3);
      bus.pop(3'h5, 8'h00);
      r(2'h0, 8'hE5, 8'h3C);
   endtask
   task t_set2;
      w(2'h0, 8'hDF, 16'h0000);
      bus.pop(3'h1, 8'hC0);
      w(2'h3, 8'h04, 16'h0011);
      w(2'h1, 8'hC4, 16'h005A);
      r(2'h2, 8'hC4, 8'h5A);
      r(2'h3, 8'h04, 8'h11);
      r(2'h0, 8'hC4, 8'h11);
      bus.pop(3'h2, 8'hC5);
      r(2'h3, 8'h04, 8'h11);
   endtask
   task t_pair_err;
      bus.acc(1'b1, 1'b1, 2'h0, 8'h20, 16'h1234);
      r(2'h0, 8'h20, 8'h12);
      r(2'h0, 8'h21, 8'h34);
      bus.acc(1'b0, 1'b1, 2'h0, 8'h21, 16'h0000);
      chk("pair", 16'h1234, rdata);
      bus.acc(1'b1, 1'b1, 2'h0, 8'hD6, 16'h1028);
      chk("ptr", 16'h1028, {plo, phi});
      w(2'h0, 8'hDF, 16'h0044);
      bus.acc(1'b0, 1'b0, 2'h0, 8'h10, 16'h0000);
      chk("err", 16'h0001, {15'h0000, err});
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge CLK);
      #1 RESET = 1'b0;
      t_reset;
      t_ptr;
      t_page;
      t_bank;
      t_set2;
      t_pair_err;
      give_verdict;
   end
endmodule // tb
`default_nettype wire
